// ---- verilog/sk_cfg.svh ----
`ifndef SK_CFG_SVH
`define SK_CFG_SVH
// Operation
// - enable rising with status on sets output
// - type selects pushbutton or latching switch
// - non-retentive: load initial status at startup
// - retentive: keep status across program restart
// - switch: output follows enable while status on
// - momentary: output high for one cycle
// - enable high and status confirmed on sets output
// - enable falling clears output
// - pushbutton: clear after one program cycle
// - status confirmed off clears output
// - pushbutton: status off-to-on with enable pulses

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SK_OFF_CTRL 12'h000
`define SK_OFF_STATUS 12'h004
`define SK_OFF_STATE 12'h008

// ----------------------------------------
// control and state field positions
// ----------------------------------------
`define SK_CTRL_TYPE 0
`define SK_CTRL_RETAIN 1
`define SK_CTRL_INIT 2
`define SK_CTRL_RUN 3
`define SK_STATE_Q 0
`define SK_STATE_STATUS 1
`define SK_STATE_EN 2
`define SK_STATE_RUN 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define SK_CTRL_RST 4'h0
`define SK_STATUS_RST 1'b0

// ----------------------------------------
// timing: program cycle
// ----------------------------------------
`define SK_CLK_NS 10
`define SK_SCAN_US 1000
`define SK_SCAN_CYCLES ((`SK_SCAN_US * 1000) / `SK_CLK_NS)
`endif

// ---- verilog/sk_pkg.sv ----
package sk_pkg;
    // program run phases
    typedef enum logic [1:0] {SK_STOPPED, SK_STARTUP, SK_RUNNING} sk_phase_t;

    // control register fields
    typedef struct packed {
        logic run;
        logic init_status;
        logic retain;
        logic switch_type;
    } sk_ctrl_t;
endpackage

// ---- verilog/sk_sync2.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module sk_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // unsynchronised level
    output logic [WIDTH-1:0] sync_out // synchronised level
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // next values
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // two stages, first read only by second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule // sk_sync2

// ---- verilog/sk_scan_tick.sv ----
`timescale 1ns/1ps
// program cycle tick generator, one-clock pulse per period
module sk_scan_tick #(
    parameter int PERIOD = 100000
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic restart, // restart the period count
    output logic tick // one-cycle pulse at period end
);
    localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_d;

    // count to the end of one program cycle
    always_comb
    begin
        tick_d = 1'b0;
        cnt_d = cnt_q + CW'(1);
        if (restart)
        begin
            cnt_d = '0;
        end
        else if (cnt_q == LAST)
        begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    // counter and tick registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // sk_scan_tick

// ---- verilog/sk_softkey.sv ----
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sk_cfg.svh"
// softkey function block with apb register access
module sk_softkey
    import sk_pkg::*;
#(
    parameter int SCAN_CYCLES = `SK_SCAN_CYCLES
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic en_in, // enable pin, asynchronous
    output logic q_out // block output
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    sk_ctrl_t ctrl_q, ctrl_d;
    sk_phase_t phase_q, phase_d;
    logic status_q, status_d;
    logic en_s;
    logic tick;
    logic restart;
    logic en_prev_q, en_prev_d;
    logic stat_prev_q, stat_prev_d;
    logic q_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic access, wr_en, mapped;
    logic [11:0] word_addr;

    // ----------------------------------------
    // enable pin and program cycle
    // ----------------------------------------
    sk_sync2 #(
        .WIDTH(1)
    ) u_en_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(en_in),
        .sync_out(en_s)
    );

    sk_scan_tick #(
        .PERIOD(SCAN_CYCLES)
    ) u_scan (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart),
        .tick(tick)
    );

    // ----------------------------------------
    // apb slave decode
    // ----------------------------------------
    // one wait state: ready rises in the second access cycle
    always_comb
    begin
        word_addr = {paddr[11:2], 2'b00};
        access = psel && penable;
        wr_en = access && pready && pwrite;
        mapped = (word_addr == `SK_OFF_CTRL) || (word_addr == `SK_OFF_STATUS)
            || (word_addr == `SK_OFF_STATE);
        pready_d = access && !pready;
        pslverr_d = access && !pready && !mapped;
        prdata_d = 32'h0000_0000;
        if (access && !pready && !pwrite)
        begin
            case (word_addr)
                `SK_OFF_CTRL: prdata_d = {28'h000_0000, ctrl_q};
                `SK_OFF_STATUS: prdata_d = {31'h0000_0000, status_q};
                `SK_OFF_STATE:
                begin
                    prdata_d[`SK_STATE_Q] = q_out;
                    prdata_d[`SK_STATE_STATUS] = status_q;
                    prdata_d[`SK_STATE_EN] = en_s;
                    prdata_d[`SK_STATE_RUN] = (phase_q != SK_STOPPED);
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // configuration, status and run phase
    // ----------------------------------------
    // a run bit 0 to 1 is a program startup; a status write is a confirmed change
    always_comb
    begin
        ctrl_d = ctrl_q;
        status_d = status_q;
        phase_d = phase_q;
        restart = 1'b0;
        if (wr_en && (word_addr == `SK_OFF_CTRL))
        begin
            ctrl_d.switch_type = pwdata[`SK_CTRL_TYPE];
            ctrl_d.retain = pwdata[`SK_CTRL_RETAIN];
            ctrl_d.init_status = pwdata[`SK_CTRL_INIT];
            ctrl_d.run = pwdata[`SK_CTRL_RUN];
        end
        if (wr_en && (word_addr == `SK_OFF_STATUS))
        begin
            status_d = pwdata[0]; // operator confirm
        end
        case (phase_q)
            SK_STOPPED:
            begin
                if (ctrl_d.run)
                begin
                    phase_d = SK_STARTUP;
                    restart = 1'b1;
                end
            end
            SK_STARTUP:
            begin
                if (!ctrl_q.run)
                begin
                    phase_d = SK_STOPPED;
                end
                else if (tick)
                begin
                    // initial status unless retentive, which keeps it
                    if (!ctrl_q.retain)
                    begin
                        status_d = ctrl_q.init_status;
                    end // else status_q held
                    phase_d = SK_RUNNING;
                end
            end
            SK_RUNNING:
            begin
                if (!ctrl_d.run)
                begin
                    phase_d = SK_STOPPED;
                end
            end
            default: phase_d = SK_STOPPED;
        endcase
    end

    // ----------------------------------------
    // output evaluation per program cycle
    // ----------------------------------------
    // previous-cycle samples give the edges of enable and status
    always_comb
    begin
        en_prev_d = en_prev_q;
        stat_prev_d = stat_prev_q;
        q_d = q_out;
        if (phase_q == SK_STOPPED)
        begin
            q_d = 1'b0;
            en_prev_d = 1'b0;
            stat_prev_d = 1'b0;
        end
        else if (tick)
        begin
            en_prev_d = en_s;
            stat_prev_d = status_q;
            if (!en_s || !status_q)
            begin
                q_d = 1'b0;
            end
            else if (ctrl_q.switch_type)
            begin
                q_d = 1'b1;
            end
            else
            begin
                // pulse only on an enable rise or a status rise
                q_d = (!en_prev_q || !stat_prev_q) && !q_out;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= sk_ctrl_t'(`SK_CTRL_RST);
            status_q <= `SK_STATUS_RST;
            phase_q <= SK_STOPPED;
            en_prev_q <= 1'b0;
            stat_prev_q <= 1'b0;
            q_out <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            status_q <= status_d;
            phase_q <= phase_d;
            en_prev_q <= en_prev_d;
            stat_prev_q <= stat_prev_d;
            q_out <= q_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end
endmodule // sk_softkey

// ---- tb/sk_prog_model.sv ----
`timescale 1ns/1ps
// program logic driving the enable pin, one clock late
module sk_prog_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic en_req, // wanted enable level
    output logic en_in // enable pin
);
    // plain level, changed only just after an edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_in <= 1'b0;
        else
            en_in <= en_req;
    end
endmodule // sk_prog_model

// ---- tb/sk_softkey_checker.sv ----
`timescale 1ns/1ps
// port checker for the softkey block
module sk_softkey_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic en_in, // enable pin
    input wire logic q_out // block output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] ctrl_q;
    logic [3:0] ctrl_d;
    logic done;
    logic ctrl_wr;
    // shadow of the control word
    assign done = psel && penable && pready;
    assign ctrl_wr = done && pwrite && (paddr[11:2] == 10'h000);
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (ctrl_wr)
            ctrl_d = pwdata[3:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= 4'h0;
        else
            ctrl_q <= ctrl_d;
    end
    sequence s_en_low;
        $fell(en_in) ##1 !en_in [*7];
    endsequence
    sequence s_access;
        $rose(penable) && psel;
    endsequence
    property p_en_fall;
        s_en_low |-> ##[0:5] !q_out;
    endproperty
    property p_mom_len;
        $rose(q_out) && !ctrl_q[0] |-> q_out [*8] ##1 !q_out;
    endproperty
    property p_rise_en;
        $rose(q_out) |-> $past(en_in, 3) && ctrl_q[3];
    endproperty
    property p_run_off;
        ctrl_wr && !pwdata[3] |-> ##[1:2] !q_out;
    endproperty
    property p_rdy_wait;
        s_access |-> !pready ##1 pready;
    endproperty
    property p_err_pair;
        pslverr |-> pready;
    endproperty
    property p_unmapped;
        done && (paddr[11:2] > 10'h002) |-> pslverr;
    endproperty
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_en_fall: assert property (p_en_fall) else $error("output held after enable fell");
    a_mom_len: assert property (p_mom_len) else $error("pulse not one cycle long");
    a_rise_en: assert property (p_rise_en) else $error("output rose without enable");
    a_run_off: assert property (p_run_off) else $error("output held while stopped");
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready not after one wait");
    a_err_pair: assert property (p_err_pair) else $error("error without ready");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ready");
endmodule // sk_softkey_checker

// ---- tb/tb_sk_softkey.sv ----
`timescale 1ns/1ps
module tb_sk_softkey;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, en_req, en_in, q_out, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_fail = 0;
    int compares = 0;
    int c;
    always #5 pclk = ~pclk;
    sk_prog_model u_sk_prog_model (.pclk(pclk), .presetn(presetn), .en_req(en_req),
        .en_in(en_in));
    sk_softkey #(.SCAN_CYCLES(8)) u_sk_softkey (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .en_in(en_in), .q_out(q_out));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task test_done;
        $display("mismatches %0d of %0d compares", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until ready is seen
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
        begin
            n_fail++;
            test_done;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cnt_q(input int n);
        c = 0;
        repeat (n)
        begin
            @(posedge pclk);
            c += (q_out === 1'b1);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 12'h00C, 32'hF);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    task t_switch;
        // switch type, initial status on, so the startup load keeps status on
        apb(1'b1, 12'h000, 32'hD);
        apb(1'b1, 12'h004, 32'h1);
        en_req <= 1'b1;
        cnt_q(30);
        check({31'h0, q_out}, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        cnt_q(20);
        check({31'h0, q_out}, 32'h0);
        apb(1'b1, 12'h004, 32'h1);
        cnt_q(20);
        check({31'h0, q_out}, 32'h1);
        en_req <= 1'b0;
        cnt_q(20);
        check({31'h0, q_out}, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'hA);
    endtask
    task t_mom;
        apb(1'b1, 12'h000, 32'h0);
        en_req <= 1'b1;
        apb(1'b1, 12'h000, 32'hC);
        cnt_q(40);
        check(c, 8);
        apb(1'b1, 12'h004, 32'h0);
        cnt_q(20);
        apb(1'b1, 12'h004, 32'h1);
        cnt_q(40);
        check(c, 8);
        en_req <= 1'b0;
    endtask
    task t_init;
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'hC);
        cnt_q(20);
        apb(1'b0, 12'h008, 32'h0);
        check(rd & 32'h2, 32'h2);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h6);
        apb(1'b1, 12'h000, 32'hE);
        cnt_q(20);
        apb(1'b0, 12'h008, 32'h0);
        check(rd & 32'h2, 32'h0);
    endtask
    // reset, then every scenario in turn
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        en_req = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_switch;
        t_mom;
        t_init;
        test_done;
    end
endmodule // tb_sk_softkey
bind sk_softkey sk_softkey_checker u_sk_softkey_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .en_in(en_in), .q_out(q_out));
